/* verilog/mii_phy_port.sv */
// MAC-side MII port: transmit, receive, status, strap, management, 25 MHz output
//////////////////////////////////////////////////////////////////////////////
`include "mii_port_defines.svh"
module mii_phy_port (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        tx_clk,
  input  wire logic        tx_valid,
  input  wire logic [3:0]  tx_data,
  output logic             tx_ready,
  output logic [3:0]       txd,
  input  wire logic        txen_i,
  output logic             txen_o,
  output logic             txen_oe_n,
  input  wire logic        rx_clk,
  input  wire logic [3:0]  rxd,
  input  wire logic        rxdv,
  input  wire logic        rxer,
  output logic             rx_valid,
  output logic [3:0]       rx_data,
  output logic             rx_end,
  output logic             rx_err,
  input  wire logic        col,
  input  wire logic        crs,
  input  wire logic        ext_phy_link_n,
  input  wire logic        ext_phy_duplex,
  output logic             collision,
  output logic             carrier,
  output logic             link_up,
  output logic             full_duplex,
  output logic             mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_n,
  input  wire logic        mg_start,
  input  wire logic        mg_read,
  input  wire logic [4:0]  mg_phy,
  input  wire logic [4:0]  mg_reg,
  input  wire logic [15:0] mg_wdata,
  output logic             mg_busy,
  output logic             mg_done,
  output logic [15:0]      mg_rdata,
  output logic             ref_sel_50m,
  output logic             strap_done,
  output logic             clk25_out
);
  //////////////////////////////////////////////////////////////////////////////
  // Reset release per link domain
  logic [1:0] txr_q;
  logic [1:0] rxr_q;
  wire        tx_rst_n = txr_q[1];
  wire        rx_rst_n = rxr_q[1];

  always_ff @(posedge tx_clk or negedge nrst) begin
    if (!nrst) txr_q <= 2'b00;
    else       txr_q <= {txr_q[0], 1'b1};
  end

  always_ff @(posedge rx_clk or negedge nrst) begin
    if (!nrst) rxr_q <= 2'b00;
    else       rxr_q <= {rxr_q[0], 1'b1};
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture on the reference clock
  mii_port_pkg::strap_state_t sp_q;
  logic       ten_s1_q;
  logic       ten_s2_q;
  logic [3:0] settle_q;
  logic       sel_q;
  wire        settle_end = (settle_q == 4'(`MII_STRAP_SETTLE_CYC - 1));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ten_s1_q <= 1'b1;
      ten_s2_q <= 1'b1;
    end else begin
      ten_s1_q <= txen_i;
      ten_s2_q <= ten_s1_q;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sp_q     <= mii_port_pkg::SP_SETTLE;
      settle_q <= 4'h0;
      sel_q    <= 1'b0;
    end else if (sp_q == mii_port_pkg::SP_SETTLE) begin
      settle_q <= settle_q + 4'h1;
      if (settle_end) begin
        sel_q <= ~ten_s2_q;
        sp_q  <= mii_port_pkg::SP_DONE;
      end
    end
  end

  assign ref_sel_50m = sel_q;
  assign strap_done  = (sp_q == mii_port_pkg::SP_DONE);

  strap_sample_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sp_q == mii_port_pkg::SP_SETTLE && settle_end |=> ref_sel_50m == !$past(ten_s2_q))
    else $error("strap level not captured");

  //////////////////////////////////////////////////////////////////////////////
  // Transmit path on the PHY transmit clock
  logic       drv_s1_q;
  logic       drv_s2_q;
  logic [3:0] txd_q;
  logic       txen_q;
  logic       oe_n_q;

  always_ff @(posedge tx_clk or negedge tx_rst_n) begin
    if (!tx_rst_n) begin
      drv_s1_q <= 1'b0;
      drv_s2_q <= 1'b0;
    end else begin
      drv_s1_q <= strap_done;
      drv_s2_q <= drv_s1_q;
    end
  end

  assign tx_ready = drv_s2_q;

  always_ff @(posedge tx_clk or negedge tx_rst_n) begin
    if (!tx_rst_n) begin
      txd_q  <= 4'h0;
      txen_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= ~drv_s2_q;
      txen_q <= tx_valid && drv_s2_q;
      txd_q  <= (tx_valid && drv_s2_q) ? tx_data : 4'h0;
    end
  end

  assign txd       = txd_q;
  assign txen_o    = txen_q;
  assign txen_oe_n = oe_n_q;

  tx_nibble_a: assert property (@(posedge tx_clk) disable iff (!tx_rst_n)
    tx_valid && tx_ready |=> txd == $past(tx_data) && txen_o) else $error("nibble lost");
  tx_enable_a: assert property (@(posedge tx_clk) disable iff (!tx_rst_n)
    !(tx_valid && tx_ready) |=> !txen_o) else $error("enable held without frame");

  //////////////////////////////////////////////////////////////////////////////
  // Receive path on the PHY receive clock
  logic [3:0] rxd_q;
  logic       rxdv_q;
  logic       rxer_q;
  logic       err_q;
  logic       end_q;
  logic       errout_q;
  wire        rx_fall  = rxdv_q && !rxdv;
  wire        err_seen = err_q || (rxdv_q && rxer_q);

  always_ff @(posedge rx_clk or negedge rx_rst_n) begin
    if (!rx_rst_n) begin
      rxd_q    <= 4'h0;
      rxdv_q   <= 1'b0;
      rxer_q   <= 1'b0;
      err_q    <= 1'b0;
      end_q    <= 1'b0;
      errout_q <= 1'b0;
    end else begin
      rxd_q    <= rxd;
      rxdv_q   <= rxdv;
      rxer_q   <= rxer;
      end_q    <= rx_fall;
      errout_q <= rx_fall && err_seen;
      err_q    <= rx_fall ? 1'b0 : err_seen;
    end
  end

  assign rx_valid = rxdv_q;
  assign rx_data  = rxd_q;
  assign rx_end   = end_q;
  assign rx_err   = errout_q;

  //////////////////////////////////////////////////////////////////////////////
  // Line status synchronised to the reference clock
  logic [3:0] st_s1_q;
  logic [3:0] st_s2_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_s1_q <= 4'h4;
      st_s2_q <= 4'h4;
    end else begin
      st_s1_q <= {ext_phy_duplex, ext_phy_link_n, crs, col};
      st_s2_q <= st_s1_q;
    end
  end

  assign collision   = st_s2_q[0];
  assign carrier     = st_s2_q[1];
  assign link_up     = ~st_s2_q[2];
  assign full_duplex = st_s2_q[3];

  //////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock output
  logic [2:0] c25_q;
  logic       clk25_q;
  wire        c25_end = (c25_q == 3'(`MII_CLK25_HALF_CYC - 1));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      c25_q   <= 3'h0;
      clk25_q <= 1'b0;
    end else begin
      c25_q   <= c25_end ? 3'h0 : c25_q + 3'h1;
      clk25_q <= c25_end ? ~clk25_q : clk25_q;
    end
  end

  assign clk25_out = clk25_q;

  //////////////////////////////////////////////////////////////////////////////
  // Management engine
  mgmt_if mg_bus ();

  assign mg_bus.start = mg_start;
  assign mg_bus.rd    = mg_read;
  assign mg_bus.phy   = mg_phy;
  assign mg_bus.regad = mg_reg;
  assign mg_bus.wdata = mg_wdata;
  assign mg_busy      = mg_bus.busy;
  assign mg_done      = mg_bus.done;
  assign mg_rdata     = mg_bus.rdata;

  mii_mgmt_engine u_mgmt (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .mg        (mg_bus.eng),
    .mdc       (mdc),
    .mdio_i    (mdio_i),
    .mdio_o    (mdio_o),
    .mdio_oe_n (mdio_oe_n)
  );
endmodule : mii_phy_port

/* verilog/mii_port_defines.svh */
// Offsets-free constants of the MII port: timing counts, frame layout, codes
`ifndef MII_PORT_DEFINES_SVH
`define MII_PORT_DEFINES_SVH

`define MII_REF_MHZ          250
`define MII_MDC_HALF_NS      200
`define MII_MDC_HALF_CYC     (((`MII_MDC_HALF_NS * `MII_REF_MHZ) + 999) / 1000)
`define MII_CLK25_MHZ        25
`define MII_CLK25_HALF_CYC   (`MII_REF_MHZ / (2 * `MII_CLK25_MHZ))
`define MII_STRAP_SETTLE_NS  40
`define MII_STRAP_SETTLE_CYC (((`MII_STRAP_SETTLE_NS * `MII_REF_MHZ) + 999) / 1000)

`define MII_PREAMBLE         32'hFFFFFFFF
`define MII_SOF              2'h1
`define MII_OP_WRITE         2'h1
`define MII_OP_READ          2'h2
`define MII_TA_WRITE         2'h2
`define MII_TA_READ          2'h0
`define MII_START_BIT        6'h20
`define MII_TA_BIT           6'h2E
`define MII_DATA_BIT         6'h30
`define MII_LAST_BIT         6'h3F

`endif

/* verilog/mii_port_pkg.sv */
// Types shared by the MII port modules
package mii_port_pkg;
  typedef enum {MG_IDLE, MG_RUN} mgmt_state_t;
  typedef enum {SP_SETTLE, SP_DONE} strap_state_t;
endpackage : mii_port_pkg

/* verilog/mgmt_if.sv */
// Command carrier between the port top and the management engine
interface mgmt_if;
  logic        start;
  logic        rd;
  logic [4:0]  phy;
  logic [4:0]  regad;
  logic [15:0] wdata;
  logic        busy;
  logic        done;
  logic [15:0] rdata;
  modport mac (output start, rd, phy, regad, wdata, input busy, done, rdata);
  modport eng (input start, rd, phy, regad, wdata, output busy, done, rdata);
endinterface : mgmt_if

/* verilog/mii_mgmt_engine.sv */
// Management frame engine: MDC generation and MDIO shifting
`include "mii_port_defines.svh"
module mii_mgmt_engine (
  input  wire logic ref_clk,
  input  wire logic nrst,
  mgmt_if.eng       mg,
  output logic      mdc,
  input  wire logic mdio_i,
  output logic      mdio_o,
  output logic      mdio_oe_n
);
  mii_port_pkg::mgmt_state_t state_q;
  logic [6:0]  div_q;
  logic        mdc_q;
  logic [5:0]  bit_q;
  logic [63:0] sh_q;
  logic        rd_q;
  logic [15:0] rdata_q;
  logic        done_q;
  logic        oe_n_q;
  logic        mdio_s1_q;
  logic        mdio_s2_q;

  wire         half_tick = (div_q == 7'(`MII_MDC_HALF_CYC - 1));
  wire         busy      = (state_q == mii_port_pkg::MG_RUN);
  wire [5:0]   bit_nx    = bit_q + 6'h01;
  wire [1:0]   op_code   = mg.rd ? `MII_OP_READ : `MII_OP_WRITE;
  wire [1:0]   ta_code   = mg.rd ? `MII_TA_READ : `MII_TA_WRITE;
  wire         in_data   = (bit_q >= `MII_DATA_BIT);

  assign mdc       = mdc_q;
  assign mdio_o    = sh_q[63];
  assign mdio_oe_n = oe_n_q;
  assign mg.busy   = busy;
  assign mg.done   = done_q;
  assign mg.rdata  = rdata_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end else begin
      mdio_s1_q <= mdio_i;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequence
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= mii_port_pkg::MG_IDLE;
      div_q   <= 7'h00;
      mdc_q   <= 1'b0;
      bit_q   <= 6'h00;
      sh_q    <= 64'h0;
      rd_q    <= 1'b0;
      rdata_q <= 16'h0000;
      done_q  <= 1'b0;
      oe_n_q  <= 1'b1;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        mii_port_pkg::MG_IDLE: begin
          if (mg.start) begin
            sh_q    <= {`MII_PREAMBLE, `MII_SOF, op_code, mg.phy, mg.regad, ta_code, mg.wdata};
            rd_q    <= mg.rd;
            bit_q   <= 6'h00;
            div_q   <= 7'h00;
            oe_n_q  <= 1'b0;
            state_q <= mii_port_pkg::MG_RUN;
          end
        end
        mii_port_pkg::MG_RUN: begin
          div_q <= half_tick ? 7'h00 : div_q + 7'h01;
          if (half_tick) begin
            mdc_q <= ~mdc_q;
            if (!mdc_q && rd_q && in_data) begin
              rdata_q <= {rdata_q[14:0], mdio_s2_q};
            end
            if (mdc_q) begin
              if (bit_q == `MII_LAST_BIT) begin
                state_q <= mii_port_pkg::MG_IDLE;
                done_q  <= 1'b1;
                oe_n_q  <= 1'b1;
                sh_q    <= 64'h0;
              end else begin
                bit_q  <= bit_nx;
                sh_q   <= {sh_q[62:0], 1'b0};
                // release line from turnaround on reads
                oe_n_q <= rd_q && (bit_nx >= `MII_TA_BIT);
              end
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock idle low and half period, MDIO drive direction, preamble bits and first start bit
  mdc_idle_low_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !busy |-> !mdc) else $error("mdc toggles while idle");
  mdc_half_period_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(mdc) |-> ##50 $fell(mdc)) else $error("mdc high phase wrong length");
  read_release_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    busy && rd_q && bit_q >= `MII_TA_BIT |-> mdio_oe_n) else $error("mdio driven in read");
  write_drive_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    busy && !rd_q |-> !mdio_oe_n) else $error("mdio released in write");
  preamble_ones_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    busy && bit_q < `MII_START_BIT |-> mdio_o) else $error("preamble bit not one");
  start_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    busy && bit_q == `MII_START_BIT |-> !mdio_o) else $error("start bit not zero");
endmodule : mii_mgmt_engine

/* verification/phy_model.sv */
// Behavioural PHY facing the MII port: clocks, receive frames, transmit capture, MDIO replies
module phy_model (
  output logic        tx_clk,
  output logic        rx_clk,
  input  wire logic [3:0] txd,
  input  wire logic   txen,
  output logic [3:0]  rxd,
  output logic        rxdv,
  output logic        rxer,
  input  wire logic   mdc,
  input  wire logic   mdio,
  output logic        md_drv,
  output logic        md_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  cap[$];
  logic [63:0] sh;
  logic [5:0]  nb;
  logic [15:0] rd_val;
  initial begin
    tx_clk = 1'b0;
    forever #3 tx_clk = ~tx_clk;
  end
  initial begin
    rx_clk = 1'b0;
    #1.7;
    forever #3 rx_clk = ~rx_clk;
  end
  initial begin
    {rxd, rxdv, rxer, md_drv, md_bit} = 8'h00;
    nb = 6'h00;
    sh = 64'h0;
    rd_val = 16'hC3A5;
  end
  always @(posedge tx_clk) if (txen === 1'b1) cap.push_back(txd);
  always @(posedge mdc) begin
    sh <= {sh[62:0], mdio};
    nb <= nb + 6'h01;
    if (nb == 6'h2E && sh[11:10] == 2'h2) begin
      md_drv <= 1'b1;
      md_bit <= 1'b0;
    end else if (md_drv && nb != 6'h3F) md_bit <= rd_val[62 - nb];
    else md_drv <= 1'b0;
  end
  // one frame, then a stray error outside it
  task rx_frame(input logic [11:0] nibs, input logic [2:0] erm);
    for (int i = 0; i < 3; i++) begin
      @(posedge rx_clk);
      rxdv <= 1'b1;
      rxd <= nibs[11 - 4 * i -: 4];
      rxer <= erm[2 - i];
    end
    @(posedge rx_clk);
    rxdv <= 1'b0;
    rxd <= ~rxd;
    rxer <= 1'b1;
    @(posedge rx_clk);
    rxer <= 1'b0;
  endtask : rx_frame
endmodule : phy_model

/* verification/mii_phy_port_bench.sv */
// Self-checking bench for the MII port
module mii_phy_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, nrst, tx_clk, tx_valid, tx_ready, txen_o, txen_oe_n, rx_clk;
  logic        rxdv, rxer, rx_valid, rx_end, rx_err, col, crs, ext_phy_link_n;
  logic        ext_phy_duplex, collision, carrier, link_up, full_duplex, mdc, mdio_o;
  logic        mdio_oe_n, md_drv, md_bit, mg_start, mg_read, mg_busy, mg_done;
  logic        ref_sel_50m, strap_done, clk25_out, strap;
  logic [3:0]  tx_data, txd, rxd, rx_data;
  logic [4:0]  mg_phy, mg_reg;
  logic [15:0] mg_wdata, mg_rdata;
  logic [3:0]  rxq[$];
  logic [1:0]  errs;
  int          n_mismatch, comparisons, cyc, n_end;
  wire         mdio = !mdio_oe_n ? mdio_o : (md_drv ? md_bit : 1'b1);
  wire         txen_pin = !txen_oe_n ? txen_o : strap;

  mii_phy_port uut (.ref_clk, .nrst, .tx_clk, .tx_valid, .tx_data, .tx_ready, .txd,
    .txen_i(txen_pin), .txen_o, .txen_oe_n, .rx_clk, .rxd, .rxdv, .rxer, .rx_valid, .rx_data,
    .rx_end, .rx_err, .col, .crs, .ext_phy_link_n, .ext_phy_duplex, .collision, .carrier,
    .link_up, .full_duplex, .mdc, .mdio_i(mdio), .mdio_o, .mdio_oe_n, .mg_start, .mg_read,
    .mg_phy, .mg_reg, .mg_wdata, .mg_busy, .mg_done, .mg_rdata, .ref_sel_50m, .strap_done,
    .clk25_out);
  phy_model u_phy (.tx_clk, .rx_clk, .txd, .txen(txen_pin), .rxd, .rxdv, .rxer, .mdc, .mdio,
    .md_drv, .md_bit);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  always @(posedge rx_clk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (rx_end === 1'b1) begin
      n_end++;
      errs = {errs[0], rx_err};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wrap_up;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  task do_reset(input logic s);
    @(posedge ref_clk);
    nrst <= 1'b0;
    strap <= s;
    repeat (2) @(posedge ref_clk);
    chk({txen_oe_n, mdio_oe_n, mdc, mg_busy, tx_ready}, 5'h18);
    chk({collision, carrier, link_up, full_duplex}, 4'h0);
    nrst <= 1'b1;
    for (int i = 0; i < 40 && strap_done !== 1'b1; i++) @(posedge ref_clk);
    chk({strap_done, ref_sel_50m}, {1'b1, ~s});
    repeat (6) @(posedge tx_clk);
    chk(tx_ready, 1'b1);
  endtask : do_reset
  task t_status;
    int  r;
    logic p;
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      {col, crs, ext_phy_link_n, ext_phy_duplex} <= i ? 4'h5 : 4'hA;
      repeat (5) @(posedge ref_clk);
      chk({collision, carrier, link_up, full_duplex}, i ? 4'h7 : 4'h8);
    end
    r = 0;
    p = clk25_out;
    repeat (20) begin
      @(posedge ref_clk);
      r += int'(clk25_out && !p);
      p = clk25_out;
    end
    chk(r, 2);
  endtask : t_status
  task t_tx;
    u_phy.cap.delete();
    for (int i = 0; i < 3; i++) begin
      @(posedge tx_clk);
      tx_valid <= 1'b1;
      tx_data <= 12'hA5F >> (8 - 4 * i);
    end
    @(posedge tx_clk);
    tx_valid <= 1'b0;
    repeat (3) @(posedge tx_clk);
    chk(u_phy.cap.size(), 3);
    chk({u_phy.cap[0], u_phy.cap[1], u_phy.cap[2]}, 12'hA5F);
    chk(txen_o, 1'b0);
  endtask : t_tx
  task t_rx;
    rxq.delete();
    n_end = 0;
    u_phy.rx_frame(12'h3C9, 3'h2);
    u_phy.rx_frame(12'h7E1, 3'h0);
    repeat (4) @(posedge rx_clk);
    chk({rxq[0], rxq[1], rxq[2], rxq[3], rxq[4], rxq[5]}, 24'h3C97E1);
    chk({n_end, errs}, {32'h2, 2'h2});
  endtask : t_rx
  task t_mgmt(input logic rd, input logic [15:0] wd);
    @(posedge ref_clk);
    {mg_start, mg_read, mg_phy, mg_reg, mg_wdata} <= {1'b1, rd, 5'h13, 5'h0A, wd};
    @(posedge ref_clk);
    mg_phy <= 5'h00;
    @(posedge ref_clk);
    mg_start <= 1'b0;
    for (int i = 0; i < 7000 && mg_done !== 1'b1; i++) @(posedge ref_clk);
    chk({mg_done, mdio_oe_n}, 2'h3);
    chk(u_phy.sh, {32'hFFFFFFFF, 2'h1, rd ? 2'h2 : 2'h1, 10'h26A, 2'h2, rd ? 16'hC3A5 : wd});
    if (rd) chk(mg_rdata, 16'hC3A5);
  endtask : t_mgmt
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, strap, tx_valid, tx_data, col, crs, ext_phy_duplex} = 10'h0;
    ext_phy_link_n = 1'b1;
    {mg_start, mg_read, mg_phy, mg_reg, mg_wdata} = 28'h0;
    errs = 2'h0;
    do_reset(1'b0);
    do_reset(1'b1);
    t_status();
    t_tx();
    t_rx();
    t_mgmt(1'b0, 16'h5A3C);
    t_mgmt(1'b1, 16'h0000);
    wrap_up();
  end
endmodule : mii_phy_port_bench
